// ### rtl/swc_pkg.sv
// Package of constants and types for the sleep and wake controller
package swc_pkg;

   // ---------------------------------------------------------------
   // Program space figures
   // ---------------------------------------------------------------
   localparam logic [13:0] VECTOR_ADDR = 14'h0004; // Interrupt vector
   localparam logic [13:0] ID_BASE = 14'h2000; // First identification word
   localparam logic [13:0] ID_LAST = 14'h2003; // Last identification word
   localparam int ID_WORDS = 4; // Number of identification words
   localparam int WORD_BITS = 14; // Program word width

   // ---------------------------------------------------------------
   // Wake source bit positions
   // ---------------------------------------------------------------
   localparam int SRC_COUNT = 6; // Peripheral wake-capable sources
   localparam int SRC_TIMER1 = 0; // Timer one in asynchronous count
   localparam int SRC_CAPTURE = 1; // Capture event
   localparam int SRC_ADC_RC = 2; // Conversion on the RC clock
   localparam int SRC_COMPARATOR = 3; // Comparator output change
   localparam int SRC_PIN_CHANGE = 4; // Pin-change event
   localparam int SRC_EXT_PIN = 5; // External interrupt pin

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLOCK_HZ = 20000000; // System clock rate
   localparam int OSC_START_NS = 1000; // Least oscillator restart time
   localparam int OSC_START_CYCLES =
      (OSC_START_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
   localparam int WDT_PERIOD = 360000; // Watchdog expiry count, 18 ms
   localparam int WDT_BITS = 19; // Watchdog counter width

   // ---------------------------------------------------------------
   // Controller states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_SLEEP = 3'b001,
      ST_RESTART = 3'b010,
      ST_PREFETCH = 3'b011,
      ST_VECTOR = 3'b100
   } swc_state_type;

endpackage : swc_pkg

// ### rtl/swc_id_if.sv
// Interface carrying identification word accesses to the ID store
`timescale 1ns/1ps
interface swc_id_if;
   logic write; // Write strobe
   logic [1:0] index; // Word index
   logic [13:0] wdata; // Write data
   logic [13:0] rdata; // Registered read data
   modport ctrl (output write, output index, output wdata, input rdata);
   modport store (input write, input index, input wdata, output rdata);
endinterface : swc_id_if

// ### rtl/swc_id_store.sv
// Identification word memory with registered read data
`timescale 1ns/1ps
module swc_id_store #(
   parameter int DEPTH = swc_pkg::ID_WORDS
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   swc_id_if.store bus
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [swc_pkg::WORD_BITS-1:0] words [DEPTH]; // Word array

   // Write port; contents survive reset like nonvolatile cells
   always_ff @(posedge i_clock) begin
      if (bus.write) begin
         words[bus.index] <= bus.wdata;
      end
   end

   // Read data come from a register
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bus.rdata <= 14'h0000;
      end else begin
         bus.rdata <= words[bus.index];
      end
   end

endmodule // swc_id_store

// ### rtl/swc_sleep_wake_control.sv
// Top of the sleep and wake controller
`timescale 1ns/1ps

// What this block does
// - Halt instruction enters power-down
// - Entry clears watchdog and power-down flag, sets time-out flag, stops oscillator
// - Pins hold their drive during power-down
// - Three events leave power-down: master clear, watchdog expiry, enabled flag
// - Master clear resets; others resume
// - Power-down flag set at power-up, halt clears
// - Watchdog wake clears time-out flag
// - Only listed peripherals may wake
// - No other peripheral interrupts while asleep
// - Halt prefetches next instruction
// - Own enable gates wake; global ignored
// - Run prefetched instruction, then vector if enabled
// - Globals off with enabled flag wakes at once
// - Interrupt and watchdog wakes clear the watchdog; master clear does not
// - Pending interrupt turns halt into no-operation
// - Late interrupt: halt completes, then wakes
// - Watchdog reset never drives master clear
// - Unprotected code readable; unprotect erases flash
// - Four ID words at 2000h-2003h
// - Watchdog expiry resets awake, wakes asleep
module swc_sleep_wake_control #(
   parameter int WDT_LIMIT = swc_pkg::WDT_PERIOD,
   parameter int PIN_COUNT = 12
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_master_clear_pin,
   input wire logic i_halt_exec,
   input wire logic i_watchdog_clear_instruction,
   input wire logic i_watchdog_enable,
   input wire logic i_watchdog_tick,
   input wire logic i_global_irq_enable,
   input wire logic [5:0] i_irq_flag,
   input wire logic [5:0] i_irq_enable,
   input wire logic [5:0] i_irq_ungated,
   input wire logic [13:0] i_pc,
   input wire logic [PIN_COUNT-1:0] i_pin_out,
   input wire logic [PIN_COUNT-1:0] i_pin_oe,
   input wire logic i_code_protect,
   input wire logic i_prog_mode,
   input wire logic i_prog_read,
   input wire logic i_prog_write,
   input wire logic [13:0] i_prog_addr,
   input wire logic [13:0] i_prog_wdata,
   input wire logic i_unprotect,
   output logic o_powerdown_flag,
   output logic o_timeout_flag,
   output logic o_osc_enable,
   output logic o_core_run,
   output logic o_device_reset,
   output logic o_master_clear_oe,
   output logic [13:0] o_prefetch_addr,
   output logic o_prefetch_req,
   output logic o_vector_req,
   output logic [13:0] o_vector_addr,
   output logic [PIN_COUNT-1:0] o_pin_out,
   output logic [PIN_COUNT-1:0] o_pin_oe,
   output logic [5:0] o_irq_flag_gated,
   output logic o_flash_read_allow,
   output logic o_flash_erase,
   output logic [13:0] o_id_rdata,
   output logic o_id_valid
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   swc_pkg::swc_state_type state; // Controller state
   swc_pkg::swc_state_type next_state; // Next controller state
   logic [swc_pkg::WDT_BITS-1:0] wdt_count; // Watchdog counter
   logic [7:0] osc_count; // Oscillator restart counter
   logic wdt_expire; // Watchdog reached its limit
   logic irq_pending; // Enabled and flagged source
   logic halt_nop; // Halt seen with a pending interrupt
   logic halt_take; // Halt that really enters power-down
   logic wake_irq; // Interrupt wake request
   logic gie_latched; // Global enable at wake time
   logic id_read_pending; // ID read in flight
   swc_id_if id_bus (); // Link to the ID store

   // Only wake-capable sources count; all others are mute while asleep
   function automatic logic [5:0] wake_mask(input logic [5:0] flag,
                                            input logic [5:0] en);
      wake_mask = flag & en;
   endfunction

   // Address lies in the identification range
   function automatic logic is_id(input logic [13:0] addr);
      is_id = (addr >= swc_pkg::ID_BASE) && (addr <= swc_pkg::ID_LAST);
   endfunction

   assign wdt_expire = i_watchdog_enable &&
      (wdt_count >= swc_pkg::WDT_BITS'(WDT_LIMIT - 1)) && i_watchdog_tick;
   assign irq_pending = |wake_mask(i_irq_flag, i_irq_enable);
   assign halt_nop = i_halt_exec && irq_pending && state == swc_pkg::ST_RUN;
   assign halt_take = i_halt_exec && !halt_nop &&
      state == swc_pkg::ST_RUN;
   // Global enable deliberately not part of the wake term
   assign wake_irq = irq_pending;

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= swc_pkg::ST_RUN;
      end else if (!i_master_clear_pin) begin
         state <= swc_pkg::ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Next state decode
   always_comb begin
      next_state = state;
      unique case (state)
         swc_pkg::ST_RUN: begin
            if (halt_take) begin
               next_state = swc_pkg::ST_SLEEP;
            end
         end
         swc_pkg::ST_SLEEP: begin
            // A late interrupt still leaves after one sleep cycle
            if (wake_irq || wdt_expire) begin
               next_state = swc_pkg::ST_RESTART;
            end
         end
         swc_pkg::ST_RESTART: begin
            if (osc_count == 8'(swc_pkg::OSC_START_CYCLES)) begin
               next_state = swc_pkg::ST_PREFETCH;
            end
         end
         swc_pkg::ST_PREFETCH: begin
            // Prefetched instruction executes first
            next_state = gie_latched ? swc_pkg::ST_VECTOR
                                     : swc_pkg::ST_RUN;
         end
         swc_pkg::ST_VECTOR: begin
            next_state = swc_pkg::ST_RUN;
         end
         default: begin
            next_state = swc_pkg::ST_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Watchdog counter
   // ---------------------------------------------------------------
   // Cleared by halt entry, clear instruction and any interrupt or watchdog wake; a master clear wake leaves it
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wdt_count <= '0;
      end else if (!i_watchdog_enable) begin
         wdt_count <= '0;
      end else if (halt_take || i_watchdog_clear_instruction) begin
         wdt_count <= '0;
      end else if (state == swc_pkg::ST_SLEEP &&
                   (wake_irq || wdt_expire)) begin
         wdt_count <= '0;
      end else if (wdt_expire) begin
         wdt_count <= '0;
      end else if (i_watchdog_tick) begin
         wdt_count <= wdt_count + 1'b1; // Keeps running while asleep
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   // Power-down flag: set by power-up and master clear, cleared by halt
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_powerdown_flag <= 1'b1;
      end else if (!i_master_clear_pin) begin
         // Master clear is a reset, so it wins over a halt in the same cycle
         o_powerdown_flag <= 1'b1;
      end else if (halt_take) begin
         o_powerdown_flag <= 1'b0;
      end
   end

   // Time-out flag: set by halt, cleared by any watchdog expiry
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_timeout_flag <= 1'b1;
      end else if (wdt_expire) begin
         o_timeout_flag <= 1'b0;
      end else if (halt_take || i_watchdog_clear_instruction) begin
         o_timeout_flag <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Oscillator, core and reset control
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_osc_enable <= 1'b1;
         o_core_run <= 1'b1;
         osc_count <= 8'h00;
      end else begin
         o_osc_enable <= next_state != swc_pkg::ST_SLEEP;
         o_core_run <= next_state == swc_pkg::ST_RUN ||
            next_state == swc_pkg::ST_PREFETCH ||
            next_state == swc_pkg::ST_VECTOR;
         osc_count <= (state == swc_pkg::ST_RESTART) ?
            osc_count + 1'b1 : 8'h00;
      end
   end

   // Awake expiry or master clear resets; master clear never driven
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_device_reset <= 1'b1;
         o_master_clear_oe <= 1'b0;
      end else begin
         o_device_reset <= !i_master_clear_pin ||
            (wdt_expire && state != swc_pkg::ST_SLEEP);
         o_master_clear_oe <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Prefetch and vector
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_prefetch_addr <= 14'h0000;
         o_prefetch_req <= 1'b0;
         o_vector_req <= 1'b0;
         o_vector_addr <= swc_pkg::VECTOR_ADDR;
         gie_latched <= 1'b0;
      end else begin
         o_prefetch_req <= i_halt_exec && state == swc_pkg::ST_RUN;
         if (i_halt_exec && state == swc_pkg::ST_RUN) begin
            o_prefetch_addr <= i_pc + 14'h0001;
         end
         if (state == swc_pkg::ST_SLEEP) begin
            gie_latched <= i_global_irq_enable;
         end
         o_vector_req <= next_state == swc_pkg::ST_VECTOR;
      end
   end

   // ---------------------------------------------------------------
   // Pin hold and interrupt gating
   // ---------------------------------------------------------------
   // Pins freeze at halt so a sleeping core cannot disturb them
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pin_out <= '0;
         o_pin_oe <= '0;
      end else if (next_state == swc_pkg::ST_RUN) begin
         o_pin_out <= i_pin_out;
         o_pin_oe <= i_pin_oe;
      end
   end

   // Clock-dependent sources are mute while the clocks are stopped
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_irq_flag_gated <= 6'h00;
      end else if (state == swc_pkg::ST_SLEEP) begin
         o_irq_flag_gated <= i_irq_flag;
      end else begin
         o_irq_flag_gated <= i_irq_flag | i_irq_ungated;
      end
   end

   // ---------------------------------------------------------------
   // Programming port
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_flash_read_allow <= 1'b0;
         o_flash_erase <= 1'b0;
      end else begin
         o_flash_read_allow <= i_prog_mode && !i_code_protect;
         o_flash_erase <= i_prog_mode && i_unprotect;
      end
   end

   // ID words reachable only in program mode
   assign id_bus.write = i_prog_mode && i_prog_write &&
      is_id(i_prog_addr);
   assign id_bus.index = i_prog_addr[1:0];
   assign id_bus.wdata = i_prog_wdata;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         id_read_pending <= 1'b0;
         o_id_valid <= 1'b0;
         o_id_rdata <= 14'h0000;
      end else begin
         id_read_pending <= i_prog_mode && i_prog_read &&
            is_id(i_prog_addr);
         o_id_valid <= id_read_pending;
         if (id_read_pending) begin
            o_id_rdata <= id_bus.rdata;
         end
      end
   end

   swc_id_store #(
      .DEPTH(swc_pkg::ID_WORDS)
   ) u_id_store (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .bus(id_bus.store)
   );

endmodule // swc_sleep_wake_control

// ### bench/swc_core_model.sv
// Core model issuing a watchdog clear and then a halt
`timescale 1ns/1ps
module swc_core_model (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_go,
   input wire logic i_core_run,
   output logic o_halt_exec,
   output logic o_watchdog_clear_instruction
);
   // --------
   // Halt sequence
   // --------
   // A stopped core issues nothing, so both steps need the core running
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_watchdog_clear_instruction <= 1'b0;
         o_halt_exec <= 1'b0;
      end else begin
         o_watchdog_clear_instruction <= i_go && i_core_run;
         // Nothing follows the halt, so the next word acts as a no-operation
         o_halt_exec <= o_watchdog_clear_instruction && i_core_run;
      end
   end
endmodule // swc_core_model

// ### bench/swc_sleep_wake_control_asserts.sv
// Checker of the sleep and wake controller ports
`timescale 1ns/1ps
module swc_sleep_wake_control_asserts #(
   parameter int PIN_COUNT = 12
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_master_clear_pin,
   input wire logic i_halt_exec,
   input wire logic [5:0] i_irq_flag,
   input wire logic [5:0] i_irq_enable,
   input wire logic [13:0] i_pc,
   input wire logic i_prog_mode,
   input wire logic i_prog_read,
   input wire logic [13:0] i_prog_addr,
   input wire logic o_powerdown_flag,
   input wire logic o_timeout_flag,
   input wire logic o_osc_enable,
   input wire logic o_core_run,
   input wire logic o_device_reset,
   input wire logic o_master_clear_oe,
   input wire logic [13:0] o_prefetch_addr,
   input wire logic o_prefetch_req,
   input wire logic o_vector_req,
   input wire logic [13:0] o_vector_addr,
   input wire logic [PIN_COUNT-1:0] o_pin_out,
   input wire logic [PIN_COUNT-1:0] o_pin_oe,
   input wire logic o_id_valid
);
   // --------
   // Clocking and helpers
   // --------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // Some source is both flagged and enabled
   wire logic pend = |(i_irq_flag & i_irq_enable);
   sequence seq_halt_taken;
      i_halt_exec && o_core_run && !o_device_reset && i_master_clear_pin;
   endsequence
   // Restart without reset; a reset restart is judged elsewhere
   sequence seq_osc_restart;
      $rose(o_osc_enable) && !o_device_reset;
   endsequence
   // --------
   // Properties
   // --------
   chk_halt_enters: assert property (
      seq_halt_taken ##0 !pend |=> !o_powerdown_flag && o_timeout_flag
      && !o_osc_enable && !o_core_run && o_prefetch_req)
      else $error("halt did not enter power-down");
   chk_halt_noop: assert property (
      seq_halt_taken ##0 pend |=> o_core_run
      && $stable(o_powerdown_flag) && $stable(o_timeout_flag))
      else $error("pending halt changed state");
   chk_prefetch_pc: assert property (
      seq_halt_taken ##0 !pend |=>
      o_prefetch_addr == $past(i_pc) + 14'h0001)
      else $error("prefetch address wrong");
   chk_wake_quick: assert property (
      !o_osc_enable && pend && i_master_clear_pin |=> o_osc_enable)
      else $error("enabled source did not wake");
   chk_resume_late: assert property (
      seq_osc_restart |-> !o_core_run [*8] ##[1:30] o_core_run)
      else $error("core resumed at wrong time");
   chk_master_clear_pin_oe: assert property (
      o_master_clear_oe == 1'b0)
      else $error("master clear driven");
   chk_master_clear_pin_reset: assert property (
      !i_master_clear_pin |=> o_device_reset && o_powerdown_flag)
      else $error("master clear did not reset");
   chk_pins_frozen: assert property (
      !o_core_run |=> $stable(o_pin_out) && $stable(o_pin_oe))
      else $error("pins moved while stopped");
   chk_vector_addr: assert property (
      o_vector_req |-> o_vector_addr == swc_pkg::VECTOR_ADDR && o_core_run)
      else $error("vector request wrong");
   chk_id_answer: assert property (
      i_prog_mode && i_prog_read && i_prog_addr
      inside {[swc_pkg::ID_BASE:swc_pkg::ID_LAST]} |-> ##2 o_id_valid)
      else $error("ID read not answered");
endmodule // swc_sleep_wake_control_asserts

bind swc_sleep_wake_control swc_sleep_wake_control_asserts #(
   .PIN_COUNT(PIN_COUNT)) swc_sleep_wake_control_asserts_i (
   .i_clock, .i_reset_n, .i_master_clear_pin, .i_halt_exec, .i_irq_flag,
   .i_irq_enable, .i_pc, .i_prog_mode, .i_prog_read, .i_prog_addr,
   .o_powerdown_flag, .o_timeout_flag, .o_osc_enable, .o_core_run,
   .o_device_reset, .o_master_clear_oe, .o_prefetch_addr, .o_prefetch_req,
   .o_vector_req, .o_vector_addr, .o_pin_out, .o_pin_oe, .o_id_valid);

// ### bench/swc_sleep_wake_control_tb.sv
// Self-checking bench of the sleep and wake controller
`timescale 1ns/1ps
module swc_sleep_wake_control_tb;
   // --------
   // Signals
   // --------
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic master_clear_pin = 1'b1;
   logic wden = 1'b0, tick = 1'b0, global_irq_enable = 1'b0, go = 1'b0;
   logic pmode = 1'b0, pread = 1'b0, pwrite = 1'b0;
   logic [5:0] flag = 6'h00, en = 6'h00;
   logic [5:0] ung = 6'h00; // Flags of clock-dependent sources
   logic cp = 1'b0, unp = 1'b0; // Code protect and unprotect levels
   logic [13:0] pc = 14'h0000, paddr = 14'h0000, pwdata = 14'h0000;
   logic [11:0] pin_o = 12'h000, pin_e = 12'h000;
   logic halt, wclr, pd, to, osc, run, drst, moe, preq, vreq, idv, fra, fer;
   logic [13:0] pfa, va, idd;
   logic [11:0] po, pe;
   logic [5:0] gated;
   int num_errors = 0;
   int compares = 0;
   // 20 MHz clock
   always #25 clock = ~clock;
   // --------
   // Design and core model
   // --------
   swc_sleep_wake_control #(.WDT_LIMIT(16), .PIN_COUNT(12))
   swc_sleep_wake_control_i (
      .i_clock(clock), .i_reset_n(reset_n), .i_master_clear_pin(master_clear_pin),
      .i_halt_exec(halt), .i_watchdog_clear_instruction(wclr),
      .i_watchdog_enable(wden), .i_watchdog_tick(tick),
      .i_global_irq_enable(global_irq_enable), .i_irq_flag(flag), .i_irq_enable(en),
      .i_irq_ungated(ung), .i_pc(pc), .i_pin_out(pin_o), .i_pin_oe(pin_e),
      .i_code_protect(cp), .i_prog_mode(pmode), .i_prog_read(pread),
      .i_prog_write(pwrite), .i_prog_addr(paddr), .i_prog_wdata(pwdata),
      .i_unprotect(unp), .o_powerdown_flag(pd), .o_timeout_flag(to),
      .o_osc_enable(osc), .o_core_run(run), .o_device_reset(drst),
      .o_master_clear_oe(moe), .o_prefetch_addr(pfa), .o_prefetch_req(preq),
      .o_vector_req(vreq), .o_vector_addr(va), .o_pin_out(po),
      .o_pin_oe(pe), .o_irq_flag_gated(gated), .o_flash_read_allow(fra),
      .o_flash_erase(fer), .o_id_rdata(idd), .o_id_valid(idv));
   swc_core_model swc_core_model_i (.i_clock(clock), .i_reset_n(reset_n),
      .i_go(go), .i_core_run(run), .o_halt_exec(halt),
      .o_watchdog_clear_instruction(wclr));
   // --------
   // Shared tasks
   // --------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick_n(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Asks the core model to halt, then waits a bounded time for sleep
   task automatic go_sleep;
      int n;
      n = 0;
      @(posedge clock);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      while (osc !== 1'b0 && n < 10) begin
         @(negedge clock);
         n++;
      end
      check(osc, 1'b0);
   endtask
   // Bounded watch for the resume, noting any vector request
   // The reset request is a one-cycle pulse, so it is watched every cycle
   task automatic wake_wait(output logic vec, output logic rst);
      vec = 1'b0;
      rst = 1'b0;
      repeat (60) begin
         @(negedge clock);
         if (vreq === 1'b1) vec = 1'b1;
         if (drst !== 1'b0) rst = 1'b1;
      end
      check(run, 1'b1);
   endtask
   task automatic tally_and_finish;
      $display("Compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_reset;
      @(negedge clock);
      check(pd, 1'b1);
      check(moe, 1'b0);
      $display("test reset done");
   endtask
   // Pending enabled flag turns the halt into a no-operation
   task automatic t_noop;
      @(posedge clock);
      flag <= 6'h01;
      en <= 6'h01;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      tick_n(6);
      @(negedge clock);
      check(pd, 1'b1);
      check(run, 1'b1);
      @(posedge clock);
      flag <= 6'h00;
      en <= 6'h00;
      $display("test noop done");
   endtask
   // Flag alone must not wake; flag with enable must
   task automatic t_irq(input int s);
      logic v, r;
      @(posedge clock);
      global_irq_enable <= s[0];
      pc <= 14'h0100 + 14'(s);
      pin_o <= 12'hA5C;
      pin_e <= 12'h0F3;
      go_sleep;
      check(pfa, 14'h0101 + 14'(s));
      check(pd, 1'b0);
      check(to, 1'b1);
      @(posedge clock);
      pin_o <= 12'h3A5;
      pin_e <= 12'hF0C;
      flag <= 6'h01 << s;
      ung <= 6'h3F;
      tick_n(30);
      @(negedge clock);
      check(osc, 1'b0);
      check(gated, 6'h01 << s);
      check(po, 12'hA5C);
      check(pe, 12'h0F3);
      @(posedge clock);
      en <= 6'h01 << s;
      wake_wait(v, r);
      check(v, s[0]);
      check(r, 1'b0);
      check(gated, 6'h3F);
      @(posedge clock);
      flag <= 6'h00;
      en <= 6'h00;
      ung <= 6'h00;
      $display("test wake source %0d done", s);
   endtask
   // Watchdog expiry wakes without reset and clears the time-out flag
   task automatic t_wdt;
      logic v, r;
      @(posedge clock);
      wden <= 1'b1;
      go_sleep;
      @(posedge clock);
      tick <= 1'b1;
      tick_n(16);
      tick <= 1'b0;
      wake_wait(v, r);
      check(to, 1'b0);
      check(r, 1'b0);
      // Ten ticks asleep, then an interrupt wake must restart the count
      go_sleep;
      @(posedge clock);
      tick <= 1'b1;
      tick_n(10);
      tick <= 1'b0;
      flag <= 6'h01;
      en <= 6'h01;
      wake_wait(v, r);
      @(posedge clock);
      flag <= 6'h00;
      en <= 6'h00;
      tick <= 1'b1;
      tick_n(10);
      tick <= 1'b0;
      @(negedge clock);
      check(to, 1'b1);
      @(posedge clock);
      wden <= 1'b0;
      $display("test watchdog done");
   endtask
   task automatic t_master_clear_pin;
      go_sleep;
      @(posedge clock);
      master_clear_pin <= 1'b0;
      tick_n(2);
      @(negedge clock);
      check(drst, 1'b1);
      check(pd, 1'b1);
      @(posedge clock);
      master_clear_pin <= 1'b1;
      tick_n(4);
      @(negedge clock);
      check(drst, 1'b0);
      $display("test master clear done");
   endtask
   // Writes four words, reads them back and one place past the end
   task automatic t_id;
      @(posedge clock);
      pmode <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         pwrite <= 1'b1;
         paddr <= 14'h2000 + 14'(i);
         pwdata <= 14'h1A50 + 14'(i);
      end
      @(posedge clock);
      pwrite <= 1'b0;
      @(negedge clock);
      check(fra, 1'b1);
      check(fer, 1'b0);
      for (int i = 0; i < 5; i++) begin
         @(posedge clock);
         pread <= 1'b1;
         paddr <= 14'h2000 + 14'(i);
         @(posedge clock);
         pread <= 1'b0;
         tick_n(1);
         @(negedge clock);
         check(idv, i < 4);
         if (i < 4) check(idd, 14'h1A50 + 14'(i));
      end
      @(posedge clock);
      cp <= 1'b1;
      unp <= 1'b1;
      tick_n(1);
      @(negedge clock);
      check(fra, 1'b0);
      check(fer, 1'b1);
      @(posedge clock);
      pmode <= 1'b0;
      cp <= 1'b0;
      unp <= 1'b0;
      $display("test ID words done");
   endtask
   // --------
   // Main sequence and watchdog
   // --------
   initial begin
      tick_n(6);
      reset_n <= 1'b1;
      t_reset;
      t_noop;
      for (int s = 0; s < 6; s++) t_irq(s);
      t_wdt;
      t_master_clear_pin;
      t_id;
      tally_and_finish;
   end
   // Far beyond the expected run of about 800 cycles
   initial begin
      #250000;
      num_errors++;
      tally_and_finish;
   end
endmodule // swc_sleep_wake_control_tb
